// ---- rtl/timer8_defines.vh ----
// Register offsets, field positions, reset values and prescale counts of the 8-bit timer
`ifndef TIMER8_DEFINES_VH
`define TIMER8_DEFINES_VH
// Printed offsets are not all multiples of four: these are indices, byte address = 4 * index
`define REG_IRQ_FLAGS_IDX 8'h37
`define REG_IRQ_MASK_IDX 8'h70
`define REG_CONTROL_B_IDX 8'hB1
`define REG_COUNT_IDX 8'hB2
`define REG_COMPARE_B_IDX 8'hB4
`define REG_COMPARE_A_IDX 8'hB3
`define REG_CONTROL_A_IDX 8'hB0
// Control B fields
`define CTLB_FORCE_A 7
`define CTLB_FORCE_B 6
`define CTLB_WAVE_HIGH 3
`define CTLB_TICK_MSB 2
`define CTLB_TICK_LSB 0
// Control A fields (waveform low bits and output actions)
`define CTLA_ACTION_A_MSB 7
`define CTLA_ACTION_A_LSB 6
`define CTLA_ACTION_B_MSB 5
`define CTLA_ACTION_B_LSB 4
`define CTLA_WAVE_LOW_MSB 1
`define CTLA_WAVE_LOW_LSB 0
// Flag and mask bit positions
`define BIT_MATCH_B 2
`define BIT_MATCH_A 1
`define BIT_OVERFLOW 0
// Reset value of every register
`define REG_RESET 8'h00
// Counter limits
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00
// Prescale limits (divisor minus one) for tick codes 1..7
`define DIV_1 10'd0
`define DIV_8 10'd7
`define DIV_32 10'd31
`define DIV_64 10'd63
`define DIV_128 10'd127
`define DIV_256 10'd255
`define DIV_1024 10'd1023
// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- rtl/timer8_compare_irq_regs.v ----
// 8-bit timer/counter with two compare channels, flags, mask and AXI4-Lite register access
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.vh"

// Summary of operation
// - Force A strobe toggles/clears/sets output A, non-PWM
// - Force B strobe acts on output B, non-PWM
// - Forced match sets no flag, no clear
// - Force bits are strobes, read zero
// - Control B bits 5:4 read zero
// - Tick select picks divide 1..1024
// - Tick select zero stops the counter
// - Counter register readable and writable
// - Counter write blocks match on next tick
// - Compare registers continuously compared with counter
// - Match B request needs mask, global, flag
// - Match A request needs mask, global, flag
// - Overflow request needs mask, global, flag
// - Flag bit 2 set on match B
// - Match B flag clears on vector or one
// - Flag bit 1 set on match A
// - Match A flag clears on vector or one
// - Overflow flag on wrap or PWM bottom turn
// - Wave modes: normal, phase PWM, clear-on-match, fast PWM
// - Output action: off, toggle, clear, set
module timer8_compare_irq_regs (
	input wire clock,
	input wire resetn,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire global_irq_enable,
	input wire vector_ack_overflow,
	input wire vector_ack_match_a,
	input wire vector_ack_match_b,
	output wire irq_overflow,
	output wire irq_match_a,
	output wire irq_match_b,
	output reg wave_output_a,
	output reg wave_output_b,
	output wire wave_enable_a,
	output wire wave_enable_b
);

	// Registers
	reg [7:0] timer_count;
	reg [7:0] compare_value_a;
	reg [7:0] compare_value_b;
	reg [7:0] timer_irq_mask;
	reg [2:0] timer_irq_flags;
	reg wave_mode_high_bit;
	reg [2:0] tick_select;
	reg [1:0] wave_mode_low_bits;
	reg [1:0] output_action_a;
	reg [1:0] output_action_b;
	reg [9:0] prescale;
	reg count_down;
	reg block_match;

	// Bus handshake state
	reg aw_held;
	reg w_held;
	reg [9:0] aw_index;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire [2:0] wave_mode = {wave_mode_high_bit, wave_mode_low_bits};
	wire mode_phase = (wave_mode == 3'd1) || (wave_mode == 3'd5);
	wire mode_fast = (wave_mode == 3'd3) || (wave_mode == 3'd7);
	wire mode_clear_on_match = (wave_mode == 3'd2);
	wire mode_pwm = mode_phase || mode_fast;
	wire top_from_a = wave_mode[2] || mode_clear_on_match;
	wire [7:0] top_value = top_from_a ? compare_value_a : `COUNT_MAX;

	// Write channel acceptance; address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire aw_now = aw_held || (s_axi_awvalid && s_axi_awready);
	wire w_now = w_held || (s_axi_wvalid && s_axi_wready);
	wire [9:0] wr_index = aw_held ? aw_index : s_axi_awaddr[11:2];
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire do_write = aw_now && w_now && !s_axi_bvalid;
	// Only the low byte lane carries register data
	wire wr_lane = do_write && wr_strb[0];
	wire [7:0] wr_byte = wr_data[7:0];
	wire [9:0] rd_index = s_axi_araddr[11:2];

	function hit;
		input [9:0] idx;
		input [7:0] reg_idx;
		begin
			hit = (idx == {2'b00, reg_idx});
		end
	endfunction

	wire wr_flags = wr_lane && hit(wr_index, `REG_IRQ_FLAGS_IDX);
	wire wr_mask = wr_lane && hit(wr_index, `REG_IRQ_MASK_IDX);
	wire wr_ctlb = wr_lane && hit(wr_index, `REG_CONTROL_B_IDX);
	wire wr_ctla = wr_lane && hit(wr_index, `REG_CONTROL_A_IDX);
	wire wr_count = wr_lane && hit(wr_index, `REG_COUNT_IDX);
	wire wr_cmpa = wr_lane && hit(wr_index, `REG_COMPARE_A_IDX);
	wire wr_cmpb = wr_lane && hit(wr_index, `REG_COMPARE_B_IDX);
	wire wr_known = hit(wr_index, `REG_IRQ_FLAGS_IDX) || hit(wr_index, `REG_IRQ_MASK_IDX) ||
		hit(wr_index, `REG_CONTROL_B_IDX) || hit(wr_index, `REG_CONTROL_A_IDX) ||
		hit(wr_index, `REG_COUNT_IDX) || hit(wr_index, `REG_COMPARE_A_IDX) ||
		hit(wr_index, `REG_COMPARE_B_IDX);

	// Force strobes exist only for the write cycle, never stored
	wire force_a = wr_ctlb && wr_byte[`CTLB_FORCE_A] && !mode_pwm;
	wire force_b = wr_ctlb && wr_byte[`CTLB_FORCE_B] && !mode_pwm;

	// Prescaler limit per tick code
	reg [9:0] div_limit;
	always @* begin
		case (tick_select)
			3'd1: div_limit = `DIV_1;
			3'd2: div_limit = `DIV_8;
			3'd3: div_limit = `DIV_32;
			3'd4: div_limit = `DIV_64;
			3'd5: div_limit = `DIV_128;
			3'd6: div_limit = `DIV_256;
			3'd7: div_limit = `DIV_1024;
			default: div_limit = `DIV_1;
		endcase
	end

	// Code zero removes the tick entirely
	wire tick = (tick_select != 3'd0) && (prescale >= div_limit);

	// Matches are judged on the current count at the tick, suppressed after a count write
	wire eq_a = (timer_count == compare_value_a);
	wire eq_b = (timer_count == compare_value_b);
	wire match_a = tick && eq_a && !block_match;
	wire match_b = tick && eq_b && !block_match;
	wire at_top = (timer_count == top_value);

	// Next count and overflow per waveform mode
	reg [7:0] next_count;
	reg next_down;
	reg overflow_event;
	always @* begin
		next_count = timer_count;
		next_down = count_down;
		overflow_event = 1'b0;
		if (tick) begin
			if (mode_phase) begin
				if (!count_down) begin
					if (at_top) begin
						next_down = 1'b1;
						next_count = timer_count - 8'h01;
					end else begin
						next_count = timer_count + 8'h01;
					end
				end else if (timer_count == `COUNT_BOTTOM) begin
					next_down = 1'b0;
					next_count = timer_count + 8'h01;
					overflow_event = 1'b1;
				end else begin
					next_count = timer_count - 8'h01;
				end
			end else if (at_top) begin
				// Normal wraps at MAX, clear-on-match and fast PWM restart from bottom at top
				next_count = `COUNT_BOTTOM;
				overflow_event = !mode_clear_on_match || (timer_count == `COUNT_MAX);
			end else begin
				next_count = timer_count + 8'h01;
			end
		end
	end

	// Output action on a match; a forced match uses the same table
	function [0:0] act;
		input [1:0] action;
		input cur;
		begin
			case (action)
				2'b01: act = ~cur;
				2'b10: act = 1'b0;
				2'b11: act = 1'b1;
				default: act = cur;
			endcase
		end
	endfunction

	// PWM outputs: fast resets at bottom; phase follows direction
	function [0:0] pwm_act;
		input [1:0] action;
		input cur;
		input down;
		input phase;
		input matched;
		input bottom;
		begin
			pwm_act = cur;
			if (action[1]) begin
				if (phase && matched)
					pwm_act = action[0] ^ down;
				else if (!phase && matched)
					pwm_act = action[0];
				else if (!phase && bottom)
					pwm_act = ~action[0];
			end else if (action == 2'b01 && wave_mode_high_bit && matched) begin
				pwm_act = ~cur;
			end
		end
	endfunction

	wire at_bottom = tick && !mode_phase && at_top;
	// Toggle action in PWM only connects output A when the high mode bit is set
	assign wave_enable_a = (output_action_a != 2'b00) &&
		!(mode_pwm && output_action_a == 2'b01 && !wave_mode_high_bit);
	assign wave_enable_b = (output_action_b != 2'b00) && !(mode_pwm && output_action_b == 2'b01);

	// Counter, prescaler, control and waveform state
	always @(posedge clock) begin
		if (!resetn) begin
			timer_count <= `REG_RESET;
			compare_value_a <= `REG_RESET;
			compare_value_b <= `REG_RESET;
			timer_irq_mask <= `REG_RESET;
			wave_mode_high_bit <= 1'b0;
			tick_select <= 3'd0;
			wave_mode_low_bits <= 2'd0;
			output_action_a <= 2'd0;
			output_action_b <= 2'd0;
			prescale <= 10'd0;
			count_down <= 1'b0;
			block_match <= 1'b0;
			wave_output_a <= 1'b0;
			wave_output_b <= 1'b0;
		end else begin
			prescale <= (tick_select == 3'd0 || tick) ? 10'd0 : prescale + 10'd1;
			count_down <= next_down;
			if (wr_count) begin
				timer_count <= wr_byte;
				block_match <= 1'b1;
			end else begin
				timer_count <= next_count;
				if (tick)
					block_match <= 1'b0;
			end
			if (wr_cmpa)
				compare_value_a <= wr_byte;
			if (wr_cmpb)
				compare_value_b <= wr_byte;
			if (wr_mask)
				timer_irq_mask <= {5'b00000, wr_byte[2:0]};
			if (wr_ctlb) begin
				wave_mode_high_bit <= wr_byte[`CTLB_WAVE_HIGH];
				tick_select <= wr_byte[`CTLB_TICK_MSB:`CTLB_TICK_LSB];
			end
			if (wr_ctla) begin
				output_action_a <= wr_byte[`CTLA_ACTION_A_MSB:`CTLA_ACTION_A_LSB];
				output_action_b <= wr_byte[`CTLA_ACTION_B_MSB:`CTLA_ACTION_B_LSB];
				wave_mode_low_bits <= wr_byte[`CTLA_WAVE_LOW_MSB:`CTLA_WAVE_LOW_LSB];
			end
			if (force_a)
				wave_output_a <= act(output_action_a, wave_output_a);
			else if (mode_pwm)
				wave_output_a <= pwm_act(output_action_a, wave_output_a, count_down, mode_phase, match_a, at_bottom);
			else if (match_a)
				wave_output_a <= act(output_action_a, wave_output_a);
			if (force_b)
				wave_output_b <= act(output_action_b, wave_output_b);
			else if (mode_pwm)
				wave_output_b <= pwm_act(output_action_b, wave_output_b, count_down, mode_phase, match_b, at_bottom);
			else if (match_b)
				wave_output_b <= act(output_action_b, wave_output_b);
		end
	end

	// Flags: hardware set wins over vector or write-one clear; forced matches never set them
	wire [2:0] flag_set = {match_b, match_a, overflow_event};
	wire [2:0] flag_clear = (wr_flags ? wr_byte[2:0] : 3'b000) |
		{vector_ack_match_b, vector_ack_match_a, vector_ack_overflow};
	always @(posedge clock) begin
		if (!resetn)
			timer_irq_flags <= 3'b000;
		else
			timer_irq_flags <= flag_set | (timer_irq_flags & ~flag_clear);
	end

	assign irq_match_b = timer_irq_mask[`BIT_MATCH_B] && global_irq_enable && timer_irq_flags[`BIT_MATCH_B];
	assign irq_match_a = timer_irq_mask[`BIT_MATCH_A] && global_irq_enable && timer_irq_flags[`BIT_MATCH_A];
	assign irq_overflow = timer_irq_mask[`BIT_OVERFLOW] && global_irq_enable && timer_irq_flags[`BIT_OVERFLOW];

	// Read mux; force bits and bits 5:4 of control B always read zero
	reg [7:0] rd_byte;
	reg rd_known;
	always @* begin
		rd_known = 1'b1;
		case (1'b1)
			hit(rd_index, `REG_IRQ_FLAGS_IDX): rd_byte = {5'b00000, timer_irq_flags};
			hit(rd_index, `REG_IRQ_MASK_IDX): rd_byte = timer_irq_mask;
			hit(rd_index, `REG_CONTROL_B_IDX): rd_byte = {4'b0000, wave_mode_high_bit, tick_select};
			hit(rd_index, `REG_CONTROL_A_IDX): rd_byte = {output_action_a, output_action_b, 2'b00, wave_mode_low_bits};
			hit(rd_index, `REG_COUNT_IDX): rd_byte = timer_count;
			hit(rd_index, `REG_COMPARE_A_IDX): rd_byte = compare_value_a;
			hit(rd_index, `REG_COMPARE_B_IDX): rd_byte = compare_value_b;
			default: begin
				rd_byte = 8'h00;
				rd_known = 1'b0;
			end
		endcase
	end

	// AXI4-Lite response channels; unmapped addresses answer SLVERR
	always @(posedge clock) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_index <= 10'd0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_index <= s_axi_awaddr[11:2];
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ---- dv/timer8_chk.sv ----
// Assertion checker for the 8-bit timer register block, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module timer8_chk (
	input wire clock,
	input wire resetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire global_irq_enable,
	input wire irq_overflow,
	input wire irq_match_a,
	input wire irq_match_b,
	input wire wave_enable_a
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// A request may only stand while the global enable is set
	match_a_gate_a: assert property (irq_match_a |-> global_irq_enable)
		else $error("match A request without global enable");
	match_b_gate_a: assert property (irq_match_b |-> global_irq_enable)
		else $error("match B request without global enable");
	overflow_gate_a: assert property (irq_overflow |-> global_irq_enable)
		else $error("overflow request without global enable");
	// Both write halves taken together must answer on the next edge
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response missing");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	// A stalled read must keep its data, or the master takes a torn value
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped while stalled");
	read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	// Output connection only moves when software writes a register
	wave_config_a: assert property (!(s_axi_awvalid && s_axi_awready) && !(s_axi_wvalid && s_axi_wready)
		|=> $stable(wave_enable_a))
		else $error("output connection changed without a write");
endmodule
bind timer8_compare_irq_regs timer8_chk chk_u (.clock, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.global_irq_enable, .irq_overflow, .irq_match_a, .irq_match_b, .wave_enable_a);
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking testbench for the 8-bit timer register block
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module testbench;
	localparam logic [11:0] A_FLAGS = {2'h0, `REG_IRQ_FLAGS_IDX, 2'h0};
	localparam logic [11:0] A_MASK = {2'h0, `REG_IRQ_MASK_IDX, 2'h0};
	localparam logic [11:0] A_CTLB = {2'h0, `REG_CONTROL_B_IDX, 2'h0};
	localparam logic [11:0] A_COUNT = {2'h0, `REG_COUNT_IDX, 2'h0};
	localparam logic [11:0] A_CMPB = {2'h0, `REG_COMPARE_B_IDX, 2'h0};
	localparam logic [11:0] A_CMPA = {2'h0, `REG_COMPARE_A_IDX, 2'h0};
	localparam logic [11:0] A_CTLA = {2'h0, `REG_CONTROL_A_IDX, 2'h0};
	logic clock = 1'h0, resetn = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] bresp;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic global_irq_enable = 1'h0, vector_ack_overflow = 1'h0, vector_ack_match_a = 1'h0, vector_ack_match_b = 1'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_overflow, irq_match_a;
	wire irq_match_b, wave_output_a, wave_output_b, wave_enable_a, wave_enable_b;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int err_total = 0, comparisons = 0;
	timer8_compare_irq_regs dut_u (.clock, .resetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .global_irq_enable, .vector_ack_overflow, .vector_ack_match_a, .vector_ack_match_b,
		.irq_overflow, .irq_match_a, .irq_match_b, .wave_output_a, .wave_output_b, .wave_enable_a, .wave_enable_b);
	always #5 clock = ~clock;
	// Address and data offered together, each released once taken
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		bresp = s_axi_bresp;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge clock); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		// Answer is left waiting one cycle so a stalled read gets exercised
		@(posedge clock);
		s_axi_rready <= 1'h1;
		do @(posedge clock); while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		`CHK(d, {24'h000000, e})
	endtask
	// Hardware clear strobe lasts exactly one cycle
	task automatic pulse(input int k);
		@(posedge clock);
		if (k == 0) vector_ack_overflow <= 1'h1; else if (k == 1) vector_ack_match_a <= 1'h1;
		else vector_ack_match_b <= 1'h1;
		@(posedge clock);
		vector_ack_overflow <= 1'h0;
		vector_ack_match_a <= 1'h0;
		vector_ack_match_b <= 1'h0;
		@(posedge clock);
	endtask
	task automatic t_reset;
		logic [11:0] regs[6] = '{A_FLAGS, A_MASK, A_CTLB, A_COUNT, A_CMPB, A_CMPA};
		foreach (regs[i]) rchk(regs[i], 8'h00);
		wr(12'hFFC, 8'h55);
		`CHK(bresp, `RESP_SLVERR)
		wr(A_MASK, 8'hFF);
		rchk(A_MASK, 8'h07);
		wr(A_CTLB, 8'hF8);
		rchk(A_CTLB, 8'h08);
		wr(A_CTLB, 8'h00);
		$display("test reset and fields done");
	endtask
	task automatic t_force;
		wr(A_COUNT, 8'h33);
		wr(A_CMPA, 8'h33);
		wr(A_CTLA, 8'h72);
		wr(A_CTLB, 8'hC0);
		`CHK({wave_output_a, wave_output_b, wave_enable_a, wave_enable_b}, 4'hF)
		rchk(A_FLAGS, 8'h00);
		rchk(A_COUNT, 8'h33);
		wr(A_CTLB, 8'h80);
		`CHK(wave_output_a, 1'h0)
		wr(A_CTLA, 8'hA2);
		wr(A_CTLB, 8'hC0);
		`CHK({wave_output_a, wave_output_b}, 2'h0)
		wr(A_CTLA, 8'h53);
		wr(A_CTLB, 8'h00);
		`CHK({wave_enable_a, wave_enable_b, wave_output_a, wave_output_b}, 4'h0)
		wr(A_CTLA, 8'h00);
		$display("test force done");
	endtask
	// Four ticks per divider from 8 to 1024; the bus skew stays below one divided period
	task automatic t_prescale;
		int div[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
		for (int i = 2; i < 8; i++) begin
			wr(A_COUNT, 8'h00);
			wr(A_CTLB, i[7:0]);
			repeat (4 * div[i]) @(posedge clock);
			wr(A_CTLB, 8'h00);
			repeat (30) @(posedge clock);
			rchk(A_COUNT, 8'h04);
		end
		$display("test prescale done");
	endtask
	task automatic t_match;
		wr(A_CMPA, 8'h05);
		wr(A_CMPB, 8'h08);
		wr(A_COUNT, 8'h00);
		global_irq_enable <= 1'h1;
		wr(A_CTLB, 8'h01);
		repeat (20) @(posedge clock);
		wr(A_CTLB, 8'h00);
		rchk(A_FLAGS, 8'h06);
		`CHK({irq_match_a, irq_match_b, irq_overflow}, 3'h6)
		global_irq_enable <= 1'h0;
		@(posedge clock);
		`CHK({irq_match_a, irq_match_b}, 2'h0)
		global_irq_enable <= 1'h1;
		pulse(1);
		`CHK({irq_match_a, irq_match_b}, 2'h1)
		pulse(2);
		rchk(A_FLAGS, 8'h00);
		wr(A_COUNT, 8'hFE);
		wr(A_CTLB, 8'h01);
		wr(A_CTLB, 8'h00);
		rchk(A_FLAGS, 8'h01);
		`CHK(irq_overflow, 1'h1)
		pulse(0);
		`CHK(irq_overflow, 1'h0)
		$display("test match done");
	endtask
	// A count write landing on the compare value must not match next tick
	task automatic t_suppress;
		wr(A_CMPA, 8'h40);
		wr(A_CMPB, 8'h80);
		wr(A_COUNT, 8'h00);
		wr(A_CTLB, 8'h01);
		wr(A_COUNT, 8'h40);
		wr(A_CTLB, 8'h00);
		rchk(A_FLAGS, 8'h00);
		wr(A_CMPB, 8'h40);
		wr(A_COUNT, 8'h3F);
		wr(A_CTLB, 8'h01);
		wr(A_CTLB, 8'h00);
		rchk(A_FLAGS, 8'h06);
		wr(A_FLAGS, 8'h06);
		rchk(A_FLAGS, 8'h00);
		$display("test suppress done");
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		resetn <= 1'h1;
		t_reset;
		t_force;
		t_prescale;
		t_match;
		t_suppress;
		close_out;
	end
	// About 7000 cycles are needed; allow over four times that
	initial begin
		#300000;
		err_total++;
		close_out;
	end
endmodule
`default_nettype wire
